// >>> logic/fsx_defs.svh
// Purpose: timing constants of the vector, float and multiply execution cluster
// Assumes: one core clock at 20 MHz; all latencies, intervals and penalties are whole clock cycles
// Notes: latencies and issue intervals per operation class
`ifndef FSX_DEFS_SVH
`define FSX_DEFS_SVH

`define FSX_CLK_MHZ 20
`define FSX_NREG 32
`define FSX_LAT_VALU 1
`define FSX_IVL_VALU 1
`define FSX_NUM_VALU 2
`define FSX_LAT_VMUL128 5
`define FSX_IVL_VMUL128 2
`define FSX_LAT_VMUL64 4
`define FSX_IVL_VMUL64 1
`define FSX_LAT_FADD 5
`define FSX_IVL_FADD 1
`define FSX_LAT_FADD_PD 6
`define FSX_IVL_FADD_PD 5
`define FSX_LAT_FMUL_SS 4
`define FSX_IVL_FMUL_SS 1
`define FSX_LAT_FMUL 5
`define FSX_IVL_FMUL 2
`define FSX_LAT_FMUL_PD 9
`define FSX_IVL_FMUL_PD 9
`define FSX_LAT_IMUL32 5
`define FSX_LAT_IMUL16 6
`define FSX_IVL_IMUL 1
`define FSX_LAT_LOAD 1
`define FSX_FP_WB_EXTRA 2
`define FSX_SPLIT_PENALTY 14
`define FSX_SPLIT_BYTES 16
`define FSX_DIV_BITS_S 24
`define FSX_DIV_BITS_D 53
`define FSX_DIV_BITS_X 64

`endif

// >>> logic/fsx_pkg.sv
// Purpose: types and timing lookups of the execution cluster
// Assumes: fsx_defs.svh holds every figure
// Notes: lookups are shared by the issue control and its checks
`include "fsx_defs.svh"
package fsx_pkg;

  typedef enum logic [4:0] {
    FSX_VALU128, FSX_VALU64, FSX_VMUL128, FSX_VMUL64,
    FSX_FADD_X87, FSX_FADD_SC, FSX_FADD_PS, FSX_FADD_PD,
    FSX_FMUL_X87, FSX_FMUL_SS, FSX_FMUL_SD, FSX_FMUL_PS, FSX_FMUL_PD,
    FSX_IMUL32, FSX_IMUL16, FSX_FDIV_S, FSX_FDIV_D, FSX_FDIV_X,
    FSX_LOAD, FSX_INT_ALU
  } fsx_cls_t;

  typedef enum logic [2:0] {
    FSX_U_VALU, FSX_U_VMUL, FSX_U_FADD, FSX_U_FMUL, FSX_U_IMUL, FSX_U_DIV, FSX_U_NONE
  } fsx_unit_t;

  typedef enum logic [1:0] {
    FSX_CAT_PS, FSX_CAT_SS, FSX_CAT_PD, FSX_CAT_SD
  } fsx_cat_t;

  typedef struct packed {
    fsx_cls_t cls;
    logic thread;
    logic [4:0] dest;
    logic [4:0] src_a;
    logic [4:0] src_b;
    logic split_load;
    logic [6:0] quot_bits;
  } fsx_issue_t;

  typedef struct packed {
    logic valid;
    fsx_cat_t cat;
  } fsx_retire_t;

  typedef struct packed {
    logic retired_vector_op_count_event;
    fsx_cat_t retired_cat;
    logic divide_op_event;
    logic divider_busy_cycle_event;
    logic memory_op_replay_event;
  } fsx_events_t;

  function automatic logic [4:0] fsx_lat(input fsx_cls_t c);
    case (c)
      FSX_VALU128, FSX_VALU64, FSX_INT_ALU: fsx_lat = 5'(`FSX_LAT_VALU);
      FSX_VMUL128: fsx_lat = 5'(`FSX_LAT_VMUL128);
      FSX_VMUL64: fsx_lat = 5'(`FSX_LAT_VMUL64);
      FSX_FADD_X87, FSX_FADD_SC, FSX_FADD_PS: fsx_lat = 5'(`FSX_LAT_FADD);
      FSX_FADD_PD: fsx_lat = 5'(`FSX_LAT_FADD_PD);
      FSX_FMUL_SS: fsx_lat = 5'(`FSX_LAT_FMUL_SS);
      FSX_FMUL_X87, FSX_FMUL_SD, FSX_FMUL_PS: fsx_lat = 5'(`FSX_LAT_FMUL);
      FSX_FMUL_PD: fsx_lat = 5'(`FSX_LAT_FMUL_PD);
      FSX_IMUL32: fsx_lat = 5'(`FSX_LAT_IMUL32);
      FSX_IMUL16: fsx_lat = 5'(`FSX_LAT_IMUL16);
      FSX_LOAD: fsx_lat = 5'(`FSX_LAT_LOAD);
      default: fsx_lat = 5'h01;
    endcase
  endfunction : fsx_lat

  function automatic logic [3:0] fsx_ivl(input fsx_cls_t c);
    case (c)
      FSX_VMUL128: fsx_ivl = 4'(`FSX_IVL_VMUL128);
      FSX_VMUL64: fsx_ivl = 4'(`FSX_IVL_VMUL64);
      FSX_FADD_PD: fsx_ivl = 4'(`FSX_IVL_FADD_PD);
      FSX_FADD_X87, FSX_FADD_SC, FSX_FADD_PS: fsx_ivl = 4'(`FSX_IVL_FADD);
      FSX_FMUL_SS: fsx_ivl = 4'(`FSX_IVL_FMUL_SS);
      FSX_FMUL_X87, FSX_FMUL_SD, FSX_FMUL_PS: fsx_ivl = 4'(`FSX_IVL_FMUL);
      FSX_FMUL_PD: fsx_ivl = 4'(`FSX_IVL_FMUL_PD);
      FSX_IMUL32, FSX_IMUL16: fsx_ivl = 4'(`FSX_IVL_IMUL);
      default: fsx_ivl = 4'(`FSX_IVL_VALU);
    endcase
  endfunction : fsx_ivl

  function automatic fsx_unit_t fsx_unit(input fsx_cls_t c);
    case (c)
      FSX_VALU128, FSX_VALU64: fsx_unit = FSX_U_VALU;
      FSX_VMUL128, FSX_VMUL64: fsx_unit = FSX_U_VMUL;
      FSX_FADD_X87, FSX_FADD_SC, FSX_FADD_PS, FSX_FADD_PD: fsx_unit = FSX_U_FADD;
      FSX_FMUL_X87, FSX_FMUL_SS, FSX_FMUL_SD, FSX_FMUL_PS, FSX_FMUL_PD: fsx_unit = FSX_U_FMUL;
      FSX_IMUL32, FSX_IMUL16: fsx_unit = FSX_U_IMUL;
      FSX_FDIV_S, FSX_FDIV_D, FSX_FDIV_X: fsx_unit = FSX_U_DIV;
      default: fsx_unit = FSX_U_NONE;
    endcase
  endfunction : fsx_unit

  function automatic logic fsx_is_fp(input fsx_cls_t c);
    fsx_is_fp = (fsx_unit(c) == FSX_U_FADD) || (fsx_unit(c) == FSX_U_FMUL) || (fsx_unit(c) == FSX_U_DIV);
  endfunction : fsx_is_fp

endpackage : fsx_pkg

// >>> logic/fsx_divider.sv
// Purpose: shared radix-2 divide sequencer for both threads
// Assumes: one divide accepted only while idle; request and ready are same-clock logic
// Notes: one quotient bit per cycle, so latency follows operand significance and size
`timescale 1ns/1ps
module fsx_divider (
  input wire logic clock,
  input wire logic nrst,
  input wire logic ce,
  input wire logic req,
  input wire logic req_thread,
  input wire logic [4:0] req_dest,
  input wire fsx_pkg::fsx_cls_t req_cls,
  input wire logic [6:0] req_bits,
  output logic busy,
  output logic owner,
  output logic done,
  output logic [4:0] done_dest
);
  import fsx_pkg::*;

  typedef enum logic {FSX_DV_IDLE, FSX_DV_RUN} fsx_dv_state_t;

  fsx_dv_state_t state_reg;
  logic [6:0] iter_reg;
  logic [6:0] max_bits;
  logic [6:0] start_bits;

  always_comb begin
    case (req_cls)
      FSX_FDIV_S: max_bits = 7'(`FSX_DIV_BITS_S);
      FSX_FDIV_D: max_bits = 7'(`FSX_DIV_BITS_D);
      default: max_bits = 7'(`FSX_DIV_BITS_X);
    endcase
    // value-dependent early finish, never past the size limit
    if (req_bits == 7'h00) begin
      start_bits = 7'h01;
    end else if (req_bits > max_bits) begin
      start_bits = max_bits;
    end else begin
      start_bits = req_bits;
    end
  end

  assign busy = (state_reg == FSX_DV_RUN);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_reg <= FSX_DV_IDLE;
      iter_reg <= 7'h00;
      owner <= 1'b0;
      done_dest <= 5'h00;
    end else if (ce) begin
      case (state_reg)
        FSX_DV_IDLE: begin
          if (req) begin
            state_reg <= FSX_DV_RUN;
            iter_reg <= start_bits;
            owner <= req_thread;
            done_dest <= req_dest;
          end
        end
        FSX_DV_RUN: begin
          iter_reg <= iter_reg - 7'h01;
          if (iter_reg == 7'h01) begin
            state_reg <= FSX_DV_IDLE;
          end
        end
        default: state_reg <= FSX_DV_IDLE;
      endcase
    end
  end

  assign done = busy && (iter_reg == 7'h01) && ce;

  div_hold_a: assert property (@(posedge clock) disable iff (!nrst)
    (busy && iter_reg > 7'h01 && ce) |=> (busy && owner == $past(owner)))
    else $error("divider released or changed owner early");

endmodule : fsx_divider

// >>> logic/fsx_issue_ctrl.sv
// Purpose: issue gating and scoreboard of the vector, float and multiply cluster
// Assumes: one instruction offered per cycle by the in-order issue stage, same clock
// Notes: scoreboard counts remaining cycles until a consumer may issue
`timescale 1ns/1ps
module fsx_issue_ctrl (
  input wire logic clock,
  input wire logic nrst,
  input wire logic ce,
  input wire logic issue_valid,
  input wire fsx_pkg::fsx_issue_t issue_req,
  input wire logic mem_hazard,
  input wire fsx_pkg::fsx_retire_t retire_in,
  output logic issue_ready,
  output fsx_pkg::fsx_unit_t issue_unit,
  output logic issue_alu_sel,
  output logic [`FSX_NREG-1:0] reg_busy,
  output logic div_done,
  output logic [4:0] div_done_dest,
  output fsx_pkg::fsx_events_t events
);
  import fsx_pkg::*;

  localparam int NUNIT = 5;

  logic [4:0] sb_reg [`FSX_NREG];
  logic [`FSX_NREG-1:0] div_hold_reg;
  logic [3:0] unit_cnt_reg [NUNIT];
  logic alu_sel_reg;
  logic fire;
  logic src_busy;
  logic unit_busy;
  logic short_op;
  logic div_busy;
  logic div_owner;
  logic [4:0] lat_next;
  fsx_unit_t req_unit;

  ////////////////////////////////////////////////////////////////////////////
  // issue decision

  always_comb begin
    for (int i = 0; i < `FSX_NREG; i++) begin
      reg_busy[i] = (sb_reg[i] != 5'h00) || div_hold_reg[i];
    end
  end

  assign req_unit = fsx_unit(issue_req.cls);
  // the destination is checked as well so an older long write cannot land late
  assign src_busy = reg_busy[issue_req.src_a] || reg_busy[issue_req.src_b] || reg_busy[issue_req.dest];
  assign short_op = (fsx_lat(issue_req.cls) == 5'h01) && (req_unit != FSX_U_DIV);

  always_comb begin
    case (req_unit)
      FSX_U_NONE: unit_busy = 1'b0;
      FSX_U_DIV: unit_busy = div_busy;
      default: unit_busy = (unit_cnt_reg[req_unit] != 4'h0);
    endcase
  end

  assign issue_ready = !src_busy && !unit_busy && !(mem_hazard && short_op);
  assign fire = issue_valid && issue_ready && ce;
  assign issue_unit = req_unit;
  assign issue_alu_sel = alu_sel_reg;

  // readiness counts from one cycle after issue, FP producers add writeback slip
  always_comb begin
    lat_next = fsx_lat(issue_req.cls) - 5'h01;
    if (fsx_is_fp(issue_req.cls)) begin
      lat_next = lat_next + 5'(`FSX_FP_WB_EXTRA);
    end
    if (issue_req.cls == FSX_LOAD && issue_req.split_load) begin
      lat_next = lat_next + 5'(`FSX_SPLIT_PENALTY);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register scoreboard

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < `FSX_NREG; i++) begin
        sb_reg[i] <= 5'h00;
      end
    end else if (ce) begin
      for (int i = 0; i < `FSX_NREG; i++) begin
        if (fire && issue_req.dest == 5'(i) && req_unit != FSX_U_DIV) begin
          sb_reg[i] <= lat_next;
        end else if (sb_reg[i] != 5'h00) begin
          sb_reg[i] <= sb_reg[i] - 5'h01;
        end
      end
    end
  end

  // divide results have no fixed latency; the destination waits for completion
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      div_hold_reg <= '0;
    end else if (ce) begin
      for (int i = 0; i < `FSX_NREG; i++) begin
        if (fire && req_unit == FSX_U_DIV && issue_req.dest == 5'(i)) begin
          div_hold_reg[i] <= 1'b1;
        end else if (div_done && div_done_dest == 5'(i)) begin
          div_hold_reg[i] <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // unit occupancy

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int u = 0; u < NUNIT; u++) begin
        unit_cnt_reg[u] <= 4'h0;
      end
    end else if (ce) begin
      for (int u = 0; u < NUNIT; u++) begin
        if (fire && req_unit == fsx_unit_t'(u)) begin
          unit_cnt_reg[u] <= fsx_ivl(issue_req.cls) - 4'h1;
        end else if (unit_cnt_reg[u] != 4'h0) begin
          unit_cnt_reg[u] <= unit_cnt_reg[u] - 4'h1;
        end
      end
    end
  end

  // two vector ALUs share the slot; alternate so each sees every other op
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      alu_sel_reg <= 1'b0;
    end else if (ce && fire && req_unit == FSX_U_VALU) begin
      alu_sel_reg <= !alu_sel_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared divider

  fsx_divider u_div (
    .clock(clock),
    .nrst(nrst),
    .ce(ce),
    .req(fire && req_unit == FSX_U_DIV),
    .req_thread(issue_req.thread),
    .req_dest(issue_req.dest),
    .req_cls(issue_req.cls),
    .req_bits(issue_req.quot_bits),
    .busy(div_busy),
    .owner(div_owner),
    .done(div_done),
    .done_dest(div_done_dest)
  );

  ////////////////////////////////////////////////////////////////////////////
  // performance events

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      events <= '0;
    end else if (ce) begin
      events.retired_vector_op_count_event <= retire_in.valid;
      events.retired_cat <= retire_in.cat;
      events.divide_op_event <= fire && req_unit == FSX_U_DIV;
      events.divider_busy_cycle_event <= div_busy;
      events.memory_op_replay_event <= issue_valid && mem_hazard && short_op;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  valu_free_a: assert property (@(posedge clock) disable iff (!nrst)
    unit_cnt_reg[FSX_U_VALU] == 4'h0)
    else $error("vector alu not free every cycle");

  vmul_wide_a: assert property (@(posedge clock) disable iff (!nrst)
    (fire && issue_req.cls == FSX_VMUL128) |=> (unit_cnt_reg[FSX_U_VMUL] == 4'h1))
    else $error("wide vector multiply interval wrong");

  faddpd_hold_a: assert property (@(posedge clock) disable iff (!nrst)
    (fire && issue_req.cls == FSX_FADD_PD) |=> (unit_cnt_reg[FSX_U_FADD] == 4'h4))
    else $error("packed double add interval wrong");

  fmulpd_hold_a: assert property (@(posedge clock) disable iff (!nrst)
    (fire && issue_req.cls == FSX_FMUL_PD && ce) |=> (!ce || unit_cnt_reg[FSX_U_FMUL] == 4'h8) ##1
    (!ce || unit_cnt_reg[FSX_U_FMUL] != 4'h0))
    else $error("packed double multiply released early");

  imul_short_a: assert property (@(posedge clock) disable iff (!nrst)
    (fire && issue_req.cls == FSX_IMUL16) |=> (sb_reg[$past(issue_req.dest)] == 5'h05))
    else $error("16-bit multiply latency wrong");

  fp_slip_a: assert property (@(posedge clock) disable iff (!nrst)
    (fire && issue_req.cls == FSX_FADD_SC) |=> (sb_reg[$past(issue_req.dest)] == 5'h06))
    else $error("fp writeback slip missing");

  split_load_a: assert property (@(posedge clock) disable iff (!nrst)
    (fire && issue_req.cls == FSX_LOAD && issue_req.split_load) |=> (sb_reg[$past(issue_req.dest)] == 5'h0E))
    else $error("split load penalty wrong");

  hazard_block_a: assert property (@(posedge clock) disable iff (!nrst)
    (mem_hazard && short_op) |-> !issue_ready)
    else $error("short op issued under memory hazard");

  div_share_a: assert property (@(posedge clock) disable iff (!nrst)
    (div_busy && req_unit == FSX_U_DIV) |-> !issue_ready)
    else $error("second divide entered busy divider");

  div_owner_a: assert property (@(posedge clock) disable iff (!nrst)
    (fire && req_unit == FSX_U_DIV) |=> (div_owner == $past(issue_req.thread)))
    else $error("divider owner is not the issuing thread");

  div_event_a: assert property (@(posedge clock) disable iff (!nrst)
    (ce && div_busy) |=> events.divider_busy_cycle_event)
    else $error("divider busy cycle not counted");

  dep_stall_a: assert property (@(posedge clock) disable iff (!nrst)
    (reg_busy[issue_req.src_a] || reg_busy[issue_req.src_b]) |-> !issue_ready)
    else $error("dependent op issued early");

endmodule : fsx_issue_ctrl

// >>> sim/fsx_stage_model.sv
// Purpose: in-order issue stage feeding the cluster issue control
// Assumes: offers change at the falling edge; ready is sampled before the rising edge
// Notes: a released request shows the inverse of its last value, never a stale copy
`timescale 1ns/1ps
module fsx_stage_model (
  input wire logic clock,
  input wire logic ce,
  input wire logic issue_ready,
  input wire fsx_pkg::fsx_unit_t issue_unit,
  output logic issue_valid,
  output fsx_pkg::fsx_issue_t issue_req
);
  import fsx_pkg::*;

  initial begin
    issue_valid = 1'b0;
    issue_req = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // offer held until an edge that sees ready; waits counts refused edges
  task automatic send(input fsx_issue_t r, output int waits, output fsx_unit_t u);
    logic rdy;
    waits = 0;
    @(negedge clock);
    issue_valid = 1'b1;
    issue_req = r;
    forever begin
      #1;
      rdy = issue_ready & ce;
      u = issue_unit;
      @(posedge clock);
      if (rdy) break;
      waits++;
      @(negedge clock);
    end
  endtask : send

  // valid is left high by send so back-to-back offers never toggle it
  task automatic release_bus(input int n);
    @(negedge clock);
    issue_valid = 1'b0;
    issue_req = fsx_issue_t'(~issue_req);
    repeat (n - 1) @(negedge clock);
  endtask : release_bus
endmodule : fsx_stage_model

// >>> sim/tb_fsx_issue_ctrl.sv
// Purpose: self-checking bench of the cluster issue control
// Assumes: inputs change at the falling edge; 50 ns clock
// Notes: table rows cover every class; hand tests cover the odd cases
`timescale 1ns/1ps
`include "fsx_defs.svh"
module tb_fsx_issue_ctrl;
  import fsx_pkg::*;
  typedef struct {
    fsx_cls_t cls;
    logic split;
    logic [6:0] q;
    fsx_unit_t u;
    int busy;
    int wt;
  } fsx_row_t;

  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic ce;
  logic mem_hazard;
  fsx_retire_t retire_in;
  logic issue_valid, issue_ready, issue_alu_sel, div_done;
  fsx_issue_t issue_req;
  fsx_unit_t issue_unit;
  logic [`FSX_NREG-1:0] reg_busy;
  logic [4:0] div_done_dest;
  fsx_events_t events;
  int error_cnt = 0;
  int comparisons = 0;
  fsx_issue_t a;
  int w;
  fsx_unit_t u;
  // busy = cycles the dest stays unreadable, wt = refused edges of a same-class follower
  fsx_row_t rows [23] = '{
    '{FSX_VALU128, 1'b0, 7'h00, FSX_U_VALU, 0, 0}, '{FSX_VALU64, 1'b0, 7'h00, FSX_U_VALU, 0, 0},
    '{FSX_VMUL128, 1'b0, 7'h00, FSX_U_VMUL, 4, 1}, '{FSX_VMUL64, 1'b0, 7'h00, FSX_U_VMUL, 3, 0},
    '{FSX_FADD_X87, 1'b0, 7'h00, FSX_U_FADD, 6, 0}, '{FSX_FADD_SC, 1'b0, 7'h00, FSX_U_FADD, 6, 0},
    '{FSX_FADD_PS, 1'b0, 7'h00, FSX_U_FADD, 6, 0}, '{FSX_FADD_PD, 1'b0, 7'h00, FSX_U_FADD, 7, 4},
    '{FSX_FMUL_X87, 1'b0, 7'h00, FSX_U_FMUL, 6, 1}, '{FSX_FMUL_SS, 1'b0, 7'h00, FSX_U_FMUL, 5, 0},
    '{FSX_FMUL_SD, 1'b0, 7'h00, FSX_U_FMUL, 6, 1}, '{FSX_FMUL_PS, 1'b0, 7'h00, FSX_U_FMUL, 6, 1},
    '{FSX_FMUL_PD, 1'b0, 7'h00, FSX_U_FMUL, 10, 8}, '{FSX_IMUL32, 1'b0, 7'h00, FSX_U_IMUL, 4, 0},
    '{FSX_IMUL16, 1'b0, 7'h00, FSX_U_IMUL, 5, 0}, '{FSX_LOAD, 1'b0, 7'h00, FSX_U_NONE, 0, 0},
    '{FSX_LOAD, 1'b1, 7'h00, FSX_U_NONE, 14, 0}, '{FSX_INT_ALU, 1'b0, 7'h00, FSX_U_NONE, 0, 0},
    '{FSX_FDIV_S, 1'b0, 7'h02, FSX_U_DIV, 2, 2}, '{FSX_FDIV_D, 1'b0, 7'h00, FSX_U_DIV, 1, 1},
    '{FSX_FDIV_X, 1'b0, 7'h7F, FSX_U_DIV, 64, 64}, '{FSX_FDIV_D, 1'b0, 7'h64, FSX_U_DIV, 53, 53},
    '{FSX_FDIV_S, 1'b0, 7'h1E, FSX_U_DIV, 24, 24}};

  always #25 clock = ~clock;

  fsx_issue_ctrl i_dut (.clock, .nrst, .ce, .issue_valid, .issue_req, .mem_hazard, .retire_in,
    .issue_ready, .issue_unit, .issue_alu_sel, .reg_busy, .div_done, .div_done_dest, .events);
  fsx_stage_model i_stage (.clock, .ce, .issue_ready, .issue_unit, .issue_valid, .issue_req);

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk_num(input int got, input int exp);
    comparisons++;
    if (got != exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk_num

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk_val

  task automatic settle();
    for (int k = 0; k < 200 && reg_busy !== '0; k++) @(negedge clock);
    chk_val(reg_busy, '0);
  endtask : settle

  task automatic wrap_up();
    $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up

  ////////////////////////////////////////////////////////////////////////////
  task automatic run_row(input fsx_row_t r);
    int nb, nd, nop, nbe;
    logic s0;
    logic dv;
    dv = (r.u == FSX_U_DIV);
    a = '0;
    a.cls = r.cls;
    a.split_load = r.split;
    a.quot_bits = r.q;
    a.dest = 5'h01;
    s0 = issue_alu_sel;
    i_stage.send(a, w, u);
    chk_val(u, r.u);
    chk_num(w, 0);
    i_stage.release_bus(1);
    nb = 0;
    nd = 0;
    nop = 0;
    nbe = 0;
    for (int k = 0; k < 70; k++) begin
      #1;
      if (k == 0) chk_val(issue_alu_sel, s0 ^ (r.u == FSX_U_VALU));
      if (div_done === 1'b1) chk_val(div_done_dest, 5'h01);
      nb += (reg_busy[1] === 1'b1);
      nd += (div_done === 1'b1);
      nop += (events.divide_op_event === 1'b1);
      nbe += (events.divider_busy_cycle_event === 1'b1);
      @(negedge clock);
    end
    chk_num(nb, r.busy);
    chk_num(nd, dv);
    chk_num(nop, dv);
    chk_num(nbe, dv ? r.busy : 0);
    settle();
    a.dest = 5'h02;
    i_stage.send(a, w, u);
    a.dest = 5'h03;
    a.thread = 1'b1;
    i_stage.send(a, w, u);
    chk_num(w, r.wt);
    i_stage.release_bus(1);
    settle();
    $display("row %s done", r.cls.name());
  endtask : run_row

  // consumer of a long producer must wait for the dest to clear
  task automatic dep(input fsx_cls_t c, input logic sp, input int exp);
    a = '0;
    a.cls = c;
    a.split_load = sp;
    a.dest = 5'h04;
    i_stage.send(a, w, u);
    a = '0;
    a.cls = FSX_INT_ALU;
    // alternate the source slot so both operand ports are exercised
    a.src_a = sp ? 5'h04 : 5'h00;
    a.src_b = sp ? 5'h00 : 5'h04;
    a.dest = 5'h05;
    i_stage.send(a, w, u);
    chk_num(w, exp);
    i_stage.release_bus(1);
    settle();
    $display("dependency test done");
  endtask : dep

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ce = 1'b1;
    mem_hazard = 1'b0;
    retire_in = '0;
    repeat (3) @(negedge clock);
    nrst = 1'b1;
    foreach (rows[i]) run_row(rows[i]);
    chk_val(issue_ready, 1'b1);
    dep(FSX_FMUL_SS, 1'b0, 5);
    dep(FSX_LOAD, 1'b1, 14);
    a = '0;
    a.cls = FSX_IMUL32;
    a.dest = 5'h06;
    mem_hazard = 1'b1;
    i_stage.send(a, w, u);
    chk_num(w, 0);
    a.cls = FSX_VALU64;
    a.dest = 5'h07;
    fork
      i_stage.send(a, w, u);
      begin
        repeat (2) @(negedge clock);
        #1;
        chk_val(events.memory_op_replay_event, 1'b1);
        @(negedge clock);
        mem_hazard = 1'b0;
      end
    join
    chk_num(w, 2);
    i_stage.release_bus(1);
    settle();
    $display("hazard test done");
    for (int c = 0; c < 4; c++) begin
      retire_in = '{1'b1, fsx_cat_t'(c)};
      @(negedge clock);
      retire_in = '0;
      #1;
      chk_val(events.retired_vector_op_count_event, 1'b1);
      chk_val(events.retired_cat, c[1:0]);
      @(negedge clock);
    end
    $display("retire test done");
    a = '0;
    a.cls = FSX_FADD_PD;
    a.dest = 5'h08;
    i_stage.send(a, w, u);
    i_stage.release_bus(1);
    ce = 1'b0;
    repeat (10) @(negedge clock);
    #1;
    chk_val(reg_busy[8], 1'b1);
    ce = 1'b1;
    settle();
    $display("clock enable test done");
    a.cls = FSX_FMUL_PD;
    a.dest = 5'h09;
    i_stage.send(a, w, u);
    i_stage.release_bus(3);
    nrst = 1'b0;
    #1;
    chk_val(reg_busy, '0);
    chk_val(issue_ready, 1'b1);
    @(negedge clock);
    nrst = 1'b1;
    run_row(rows[12]);
    $display("reset test done");
    wrap_up();
  end

  // whole run needs about 2300 cycles
  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    $display("watchdog expired at t=%0t", $time);
    wrap_up();
  end
endmodule : tb_fsx_issue_ctrl
